// ### inc/uart_irda_consts.svh
// constants for the infrared-capable uart
`ifndef UART_IRDA_CONSTS_SVH
`define UART_IRDA_CONSTS_SVH
`define ADDR_CTL0        12'hF42
`define ADDR_CTL1        12'hF43
`define ADDR_STATUS      12'hF44
`define ADDR_TXDATA      12'hF45
`define ADDR_RXDATA      12'hF46
`define ADDR_BAUD_HI     12'hF47
`define ADDR_BAUD_LO     12'hF48
`define CTL0_RESET       8'h00
`define CTL1_RESET       8'h00
`define BAUD_RESET       16'h0001
`define BIT_TRANSMITTER  7
`define BIT_RECEIVER     6
`define BIT_CTS_GATE     5
`define BIT_PARITY       4
`define BIT_PARITY_ODD   3
`define BIT_BREAK        2
`define BIT_TWO_STOP     1
`define BIT_MP_MODE      0
`define BIT_MP_TX        1
`define BIT_IR_MODE      2
`define OVERSAMPLE       5'd16
`define IR_PULSE_START   4'd7
`define IR_PULSE_END     4'd10
`endif

// ### inc/uart_irda_pkg.sv
// types for the infrared-capable uart
package uart_irda_pkg;
  typedef enum logic [4:0] {
    TX_IDLE   = 5'b00001,
    TX_START  = 5'b00010,
    TX_DATA   = 5'b00100,
    TX_EXTRA  = 5'b01000,
    TX_STOP   = 5'b10000
  } tx_state_t;
  typedef enum logic [4:0] {
    RX_IDLE   = 5'b00001,
    RX_START  = 5'b00010,
    RX_DATA   = 5'b00100,
    RX_EXTRA  = 5'b01000,
    RX_STOP   = 5'b10000
  } rx_state_t;
endpackage : uart_irda_pkg

// ### hw/ir_bit_encoder.sv
// infrared pulse encoder for one bit period
`timescale 1ns/100ps
`include "uart_irda_consts.svh"
module ir_bit_encoder
  import uart_irda_pkg::*;
(
  input  wire logic       clock,
  input  wire logic       rst,
  input  wire logic       enable,
  input  wire logic       tick,
  input  wire logic [3:0] phase,
  input  wire logic       txBit,
  output logic            irPulse
);
  typedef struct packed {
    logic pulse;
  } enc_state_t;
  enc_state_t s_reg, s_next;
  always_comb begin
    s_next = s_reg;
    if (!enable) begin
      s_next.pulse = 1'b0;
    end else if (tick) begin
      s_next.pulse = !txBit && (phase >= `IR_PULSE_START) && (phase < `IR_PULSE_END);
    end
  end
  always_ff @(posedge clock) begin
    if (rst) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end
  assign irPulse = s_reg.pulse;
endmodule : ir_bit_encoder

// ### hw/uart_irda_transceiver.sv
// uart with multiprocessor mode, parity, cts gating and infrared endec
//
// Design decision made here: the Wishbone register port.
`timescale 1ns/100ps
`include "uart_irda_consts.svh"
module uart_irda_transceiver
  import uart_irda_pkg::*;
(
  input  wire logic        clock,
  input  wire logic        rst,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [11:0] wb_adr_i,
  input  wire logic [7:0]  wb_dat_i,
  input  wire logic        wb_sel_i,
  output logic      [7:0]  wb_dat_o,
  output logic             wb_ack_o,
  input  wire logic        rxLine,
  input  wire logic        clearToSendN,
  output logic             txLine,
  output logic             driverEnable,
  output logic             txIrq
);
  typedef struct packed {
    logic [7:0]  ctl0;
    logic [7:0]  ctl1;
    logic [15:0] baud;
    logic [15:0] divCnt;
    logic        ack;
    logic [7:0]  rdata;
    logic [7:0]  txHold;
    logic        txHoldEmpty;
    logic        txMpHold;
    tx_state_t   txState;
    logic [3:0]  txPhase;
    logic [2:0]  txIdx;
    logic [7:0]  txShift;
    logic        txExtra;
    logic        txStop2;
    logic        txBit;
    rx_state_t   rxState;
    logic [3:0]  rxPhase;
    logic [2:0]  rxIdx;
    logic [7:0]  rxShift;
    logic        rxPar;
    logic        rxPulseSeen;
    logic [7:0]  rxData;
    logic        rxAvail;
    logic        overrun;
    logic        parityErr;
    logic        frameErr;
    logic        newFrame;
    logic        multiproc_rx_bit;
    logic        rxSawAddr;
  } core_state_t;
  core_state_t s_reg, s_next;
  logic tick;
  logic access;
  logic canSend;
  logic irMode;
  logic rxIn;
  logic ninthOn;
  logic irPulse;
  logic [7:0] statusWord;
  assign access  = wb_cyc_i && wb_stb_i && !s_reg.ack;
  assign tick    = (s_reg.divCnt <= 16'h0001) || (s_reg.baud == 16'h0000);
  assign irMode  = s_reg.ctl1[`BIT_IR_MODE] &&
                   (s_reg.ctl0[`BIT_TRANSMITTER] || s_reg.ctl0[`BIT_RECEIVER]);
  assign ninthOn = s_reg.ctl0[`BIT_PARITY] || s_reg.ctl0[`BIT_MP_MODE];
  assign canSend = s_reg.ctl0[`BIT_TRANSMITTER] &&
                   (!s_reg.ctl0[`BIT_CTS_GATE] || !clearToSendN);
  assign rxIn = irMode ? !(s_reg.rxPulseSeen || rxLine) : rxLine;
  assign statusWord = {s_reg.rxAvail, s_reg.overrun, s_reg.parityErr, s_reg.frameErr,
                       s_reg.txHoldEmpty, s_reg.newFrame, s_reg.multiproc_rx_bit, 1'b0};
  always_comb begin
    s_next = s_reg;
    s_next.ack = access;
    s_next.divCnt = tick ? s_reg.baud : s_reg.divCnt - 16'h0001;
    if (access && !wb_we_i) begin
      unique case (wb_adr_i)
        `ADDR_CTL0:    s_next.rdata = s_reg.ctl0;
        `ADDR_CTL1:    s_next.rdata = s_reg.ctl1 & 8'h07;
        `ADDR_STATUS:  s_next.rdata = statusWord;
        `ADDR_RXDATA: begin
          s_next.rdata = s_reg.rxData;
          s_next.rxAvail = 1'b0;
          s_next.newFrame = 1'b0;
          s_next.multiproc_rx_bit = 1'b0;
        end
        `ADDR_BAUD_HI: s_next.rdata = s_reg.baud[15:8];
        `ADDR_BAUD_LO: s_next.rdata = s_reg.baud[7:0];
        default:       s_next.rdata = 8'h00;
      endcase
    end
    if (access && wb_we_i && wb_sel_i) begin
      unique case (wb_adr_i)
        `ADDR_CTL0:    s_next.ctl0 = wb_dat_i;
        `ADDR_CTL1:    s_next.ctl1 = wb_dat_i & 8'h07;
        `ADDR_TXDATA: begin
          if (s_reg.txHoldEmpty) begin
            s_next.txHold = wb_dat_i;
            s_next.txMpHold = s_reg.ctl1[`BIT_MP_TX];
            s_next.txHoldEmpty = 1'b0;
          end
        end
        `ADDR_BAUD_HI: s_next.baud[15:8] = wb_dat_i;
        `ADDR_BAUD_LO: s_next.baud[7:0] = wb_dat_i;
        default: ;
      endcase
    end
    if (tick) begin
      unique case (s_reg.txState)
        TX_IDLE: begin
          s_next.txBit = !s_reg.ctl0[`BIT_BREAK];
          if (!s_reg.txHoldEmpty && canSend && !(irMode && s_reg.rxState != RX_IDLE)) begin
            s_next.txShift = s_reg.txHold;
            s_next.txExtra = s_reg.ctl0[`BIT_PARITY] ?
                             ((^s_reg.txHold) ^ s_reg.ctl0[`BIT_PARITY_ODD]) : s_reg.txMpHold;
            s_next.txHoldEmpty = 1'b1;
            s_next.txState = TX_START;
            s_next.txPhase = 4'd0;
            s_next.txStop2 = s_reg.ctl0[`BIT_TWO_STOP];
            s_next.txBit = 1'b0;
          end
        end
        default: begin
          s_next.txPhase = s_reg.txPhase + 4'd1;
          if (s_reg.txPhase == 4'd15) begin
            unique case (s_reg.txState)
              TX_START: begin
                s_next.txState = TX_DATA;
                s_next.txIdx = 3'd0;
                s_next.txBit = s_reg.txShift[0];
              end
              TX_DATA: begin
                s_next.txIdx = s_reg.txIdx + 3'd1;
                s_next.txBit = s_reg.txShift[s_reg.txIdx + 3'd1];
                if (s_reg.txIdx == 3'd7) begin
                  s_next.txState = ninthOn ? TX_EXTRA : TX_STOP;
                  s_next.txBit = ninthOn ? s_reg.txExtra : 1'b1;
                end
              end
              TX_EXTRA: begin
                s_next.txState = TX_STOP;
                s_next.txBit = 1'b1;
              end
              default: begin
                s_next.txBit = 1'b1;
                if (s_reg.txStop2) begin
                  s_next.txStop2 = 1'b0;
                end else begin
                  s_next.txState = TX_IDLE;
                end
              end
            endcase
          end
        end
      endcase
    end
    if (irMode && rxLine) begin
      s_next.rxPulseSeen = 1'b1;
    end
    if (!s_reg.ctl0[`BIT_RECEIVER]) begin
      s_next.rxState = RX_IDLE;
      s_next.rxPulseSeen = 1'b0;
    end else if (tick) begin
      s_next.rxPhase = s_reg.rxPhase + 4'd1;
      if (s_reg.rxPhase == 4'd15) begin
        s_next.rxPulseSeen = 1'b0;
      end
      unique case (s_reg.rxState)
        RX_IDLE: begin
          s_next.rxPulseSeen = 1'b0;
          // no receive while sending in infrared mode
          if (!rxIn && !(irMode && s_reg.txState != TX_IDLE)) begin
            s_next.rxState = RX_START;
            s_next.rxPhase = 4'd1;
          end
        end
        RX_START: begin
          if (s_reg.rxPhase == 4'd15) begin
            s_next.rxState = RX_DATA;
            s_next.rxIdx = 3'd0;
          end
        end
        RX_DATA: begin
          if (s_reg.rxPhase == 4'd15) begin
            s_next.rxShift = {rxIn, s_reg.rxShift[7:1]};
            s_next.rxIdx = s_reg.rxIdx + 3'd1;
            if (s_reg.rxIdx == 3'd7) begin
              s_next.rxState = ninthOn ? RX_EXTRA : RX_STOP;
            end
          end
        end
        RX_EXTRA: begin
          if (s_reg.rxPhase == 4'd15) begin
            s_next.rxPar = rxIn;
            s_next.rxState = RX_STOP;
          end
        end
        default: begin
          if (s_reg.rxPhase == 4'd7) begin
            s_next.rxState = RX_IDLE;
            s_next.overrun = s_reg.rxAvail;
            s_next.rxData = s_reg.rxShift;
            s_next.rxAvail = 1'b1;
            s_next.frameErr = !rxIn;
            s_next.parityErr = s_reg.ctl0[`BIT_PARITY] &&
                               (((^s_reg.rxShift) ^ s_reg.ctl0[`BIT_PARITY_ODD]) != s_reg.rxPar);
            if (s_reg.ctl0[`BIT_MP_MODE]) begin
              s_next.multiproc_rx_bit = s_reg.rxPar;
              s_next.newFrame = !s_reg.rxPar && s_reg.rxSawAddr;
              s_next.rxSawAddr = s_reg.rxPar;
            end
          end
        end
      endcase
    end
  end
  always_ff @(posedge clock) begin
    if (rst) begin
      s_reg <= '0;
      s_reg.ctl0 <= `CTL0_RESET;
      s_reg.ctl1 <= `CTL1_RESET;
      s_reg.baud <= `BAUD_RESET;
      s_reg.txHoldEmpty <= 1'b1;
      s_reg.txBit <= 1'b1;
      s_reg.txState <= TX_IDLE;
      s_reg.rxState <= RX_IDLE;
    end else begin
      s_reg <= s_next;
    end
  end
  ir_bit_encoder encoder (
    .clock   (clock),
    .rst     (rst),
    .enable  (irMode),
    .tick    (tick),
    .phase   (s_next.txPhase),
    .txBit   (s_next.txBit),
    .irPulse (irPulse)
  );
  assign wb_ack_o = s_reg.ack;
  assign wb_dat_o = s_reg.rdata;
  assign txLine = irMode ? irPulse : s_reg.txBit;
  assign driverEnable = s_reg.txState != TX_IDLE;
  assign txIrq = s_reg.txHoldEmpty && s_reg.ctl0[`BIT_TRANSMITTER];
endmodule : uart_irda_transceiver

// ### verif/uart_irda_transceiver_monitor.sv
// port assertions for the infrared uart
`timescale 1ns/100ps
`include "uart_irda_consts.svh"
module uart_irda_transceiver_monitor (
  input wire logic        clock,
  input wire logic        rst,
  input wire logic        wb_cyc_i,
  input wire logic        wb_stb_i,
  input wire logic        wb_we_i,
  input wire logic [11:0] wb_adr_i,
  input wire logic [7:0]  wb_dat_i,
  input wire logic        wb_sel_i,
  input wire logic [7:0]  wb_dat_o,
  input wire logic        wb_ack_o,
  input wire logic        rxLine,
  input wire logic        clearToSendN,
  input wire logic        txLine,
  input wire logic        driverEnable,
  input wire logic        txIrq
);
  logic [7:0]  c0Reg;
  logic [7:0]  c1Reg;
  logic [15:0] baudReg;
  int          lowRun;
  logic        wr;
  logic        irOn;
  // mirror updates on the edge the slave takes the write
  assign wr = wb_cyc_i && wb_stb_i && wb_we_i && !wb_ack_o && wb_sel_i;
  assign irOn = c1Reg[2] && (c0Reg[7] || c0Reg[6]);
  always_ff @(posedge clock) begin
    if (rst) begin
      c0Reg <= 8'h00;
      c1Reg <= 8'h00;
      baudReg <= 16'h0001;
      lowRun <= 0;
    end else begin
      lowRun <= (txLine || irOn) ? 0 : lowRun + 1;
      if (wr && wb_adr_i == `ADDR_CTL0) c0Reg <= wb_dat_i;
      if (wr && wb_adr_i == `ADDR_CTL1) c1Reg <= wb_dat_i;
      if (wr && wb_adr_i == `ADDR_BAUD_HI) baudReg[15:8] <= wb_dat_i;
      if (wr && wb_adr_i == `ADDR_BAUD_LO) baudReg[7:0] <= wb_dat_i;
    end
  end
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);
  a_reserved_zero: assert property (
    wb_ack_o && !wb_we_i && wb_adr_i == `ADDR_STATUS |-> !wb_dat_o[0]) else $error("status b0 set");
  a_ir_pulse_three: assert property (
    irOn && baudReg == 16'h0001 && $rose(txLine) |-> txLine[*3] ##1 !txLine)
    else $error("ir pulse width");
  a_ir_gap_low: assert property (
    irOn && baudReg == 16'h0001 && $fell(txLine) |-> !txLine[*8]) else $error("ir gap");
  a_bit_multiple: assert property (
    !irOn && $rose(txLine) && lowRun > 4 |-> lowRun % (16 * baudReg) == 0)
    else $error("bit length");
  a_cts_blocks: assert property (
    c0Reg[5] && clearToSendN && $past(clearToSendN) && !driverEnable |=> !driverEnable)
    else $error("sent without cts");
  a_cts_ignored: assert property (
    wr && wb_adr_i == `ADDR_TXDATA && txIrq && !driverEnable && c0Reg[7] && !c0Reg[5]
    |-> ##[1:40] driverEnable)
    else $error("no send");
  a_irq_enabled: assert property (
    txIrq |-> c0Reg[7]) else $error("irq while off");
  a_idle_high: assert property (
    !irOn && !$past(irOn) && !$past(driverEnable) && !driverEnable ##1 !driverEnable
    |-> $past(txLine)) else $error("idle low");
endmodule : uart_irda_transceiver_monitor

// ### verif/uart_line_partner.sv
// remote serial node on the line side
`timescale 1ns/100ps
module uart_line_partner (
  input  wire logic       clock,
  input  wire logic       txLine,
  output logic            rxLine,
  output logic [8:0]      gotWord,
  output logic            gotStrobe
);
  int         bitLen = 16;
  logic       irMode = 1'b0;
  logic       listen = 1'b1;
  logic [8:0] w;
  initial begin
    rxLine = 1'b1;
    gotStrobe = 1'b0;
  end
  always begin
    @(negedge txLine);
    if (listen) begin
      repeat (bitLen / 2) @(posedge clock);
      for (int i = 0; i < 9; i++) begin
        repeat (bitLen) @(posedge clock);
        w[i] = txLine;
      end
      gotWord <= w;
      gotStrobe <= 1'b1;
      @(posedge clock);
      gotStrobe <= 1'b0;
    end
  end
  task automatic send(input logic [8:0] d, input int nb);
    logic b;
    for (int i = 0; i <= nb + 1; i++) begin
      b = (i == 0) ? 1'b0 : (i > nb) ? 1'b1 : d[i-1];
      if (irMode) begin
        repeat (bitLen * 7 / 16) @(posedge clock);
        rxLine <= !b;
        repeat (bitLen * 3 / 16) @(posedge clock);
        rxLine <= 1'b0;
        repeat (bitLen * 6 / 16) @(posedge clock);
      end else begin
        rxLine <= b;
        repeat (bitLen) @(posedge clock);
      end
    end
  endtask : send
endmodule : uart_line_partner

// ### verif/uart_irda_transceiver_bench.sv
// self-checking bench for the infrared uart
`timescale 1ns/100ps
`include "uart_irda_consts.svh"
`define CHK(n, e, g) begin num_checks++; if ((g) !== (e)) begin num_errors++; \
  $display("wrong value %s exp %h got %h", n, e, g); end end
module uart_irda_transceiver_bench;
  logic        clock = 1'b0;
  logic        rst = 1'b1;
  logic        wbCyc = 1'b0;
  logic        wbStb = 1'b0;
  logic        wbWe = 1'b0;
  logic        wbSel = 1'b0;
  logic [11:0] wbAdr = 12'h000;
  logic [7:0]  wbDatW = 8'h00;
  logic [7:0]  wbDatR, rd, d;
  logic        wbAck, rxLine, txLine, driverEnable, txIrq, gotStrobe, e9;
  logic        clearToSendN = 1'b1;
  logic [8:0]  gotWord, e;
  logic [8:0]  expQ[$];
  logic [7:0]  c0s[7] = '{8'h80, 8'h90, 8'h98, 8'h81, 8'h81, 8'h82, 8'h80};
  logic [7:0]  c1s[7] = '{8'h00, 8'h00, 8'h00, 8'h02, 8'h00, 8'h00, 8'h00};
  logic [7:0]  bds[7] = '{8'h01, 8'h01, 8'h01, 8'h01, 8'h01, 8'h01, 8'h03};
  int          num_errors = 0, num_checks = 0, cycles = 0, pulses = 0;
  always #2 clock = ~clock;
  uart_irda_transceiver u_uart_irda_transceiver (.clock(clock), .rst(rst), .wb_cyc_i(wbCyc),
    .wb_stb_i(wbStb), .wb_we_i(wbWe), .wb_adr_i(wbAdr), .wb_dat_i(wbDatW), .wb_sel_i(wbSel),
    .wb_dat_o(wbDatR), .wb_ack_o(wbAck), .rxLine(rxLine), .clearToSendN(clearToSendN),
    .txLine(txLine), .driverEnable(driverEnable), .txIrq(txIrq));
  uart_line_partner u_uart_line_partner (.clock(clock), .txLine(txLine), .rxLine(rxLine),
    .gotWord(gotWord), .gotStrobe(gotStrobe));
  task automatic test_done;
    $display("checks %0d errors %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : test_done
  always @(posedge clock) begin
    cycles++;
    if (cycles == 40000) begin
      num_errors++;
      test_done();
    end
  end
  always @(posedge txLine) pulses++;
  always @(posedge clock) begin
    if (gotStrobe === 1'b1) begin
      e = (expQ.size() != 0) ? expQ.pop_front() : 'x;
      `CHK("line word", e, gotWord)
    end
  end
  task automatic wb(input logic we, input logic [11:0] a, input logic [7:0] w);
    int n;
    n = 0;
    wbCyc <= 1'b1;
    wbStb <= 1'b1;
    wbWe <= we;
    wbAdr <= a;
    wbDatW <= w;
    wbSel <= 1'b1;
    @(posedge clock);
    while (wbAck !== 1'b1 && n < 20) begin
      @(posedge clock);
      n++;
    end
    rd = wbDatR;
    if (n == 20) num_errors++;
    wbCyc <= 1'b0;
    wbStb <= 1'b0;
    wbSel <= 1'b0;
    @(posedge clock);
  endtask : wb
  task automatic txWrite(input logic [7:0] v);
    int n;
    n = 0;
    rd = 8'h00;
    while (rd[3] !== 1'b1 && n < 500) begin
      wb(1'b0, `ADDR_STATUS, 8'h00);
      n++;
    end
    if (n == 500) num_errors++;
    wb(1'b1, `ADDR_TXDATA, v);
  endtask : txWrite
  task automatic rdChk(input logic [11:0] a, input logic [7:0] m, input logic [7:0] x);
    wb(1'b0, a, 8'h00);
    `CHK("register", x, rd & m)
  endtask : rdChk
  task automatic cfg(input logic [7:0] b, input logic [7:0] c1, input logic [7:0] c0);
    wb(1'b1, `ADDR_CTL0, 8'h00);
    wb(1'b1, `ADDR_BAUD_HI, 8'h00);
    wb(1'b1, `ADDR_BAUD_LO, b);
    wb(1'b1, `ADDR_CTL1, c1);
    wb(1'b1, `ADDR_CTL0, c0);
    u_uart_line_partner.bitLen = 16 * b;
  endtask : cfg
  task automatic waitTx;
    int n;
    n = 0;
    repeat (4) @(posedge clock);
    while (!(txIrq === 1'b1 && driverEnable === 1'b0) && n < 5000) begin
      @(posedge clock);
      n++;
    end
    repeat (20) @(posedge clock);
  endtask : waitTx
  initial begin
    void'($urandom(32'h85F37EB1));
    repeat (8) @(posedge clock);
    rst <= 1'b0;
    rdChk(`ADDR_CTL0, 8'hFF, 8'h00);
    rdChk(`ADDR_BAUD_LO, 8'hFF, 8'h01);
    wb(1'b1, 12'hF40, 8'hFF);
    rdChk(12'hF40, 8'hFF, 8'h00);
    for (int i = 0; i < 7; i++) begin
      cfg(bds[i], c1s[i], c0s[i]);
      d = 8'($urandom);
      e9 = c0s[i][4] ? (c0s[i][3] ? ~^d : ^d) : c0s[i][0] ? c1s[i][1] : 1'b1;
      expQ.push_back({e9, d});
      expQ.push_back({e9, ~d});
      rdChk(`ADDR_STATUS, 8'h09, 8'h08);
      txWrite(d);
      txWrite(~d);
      rdChk(`ADDR_STATUS, 8'h08, 8'h00);
      waitTx();
    end
    cfg(8'h01, 8'h00, 8'hA0);
    expQ.push_back({1'b1, d});
    txWrite(d);
    repeat (200) @(posedge clock);
    `CHK("cts hold", 1'b0, driverEnable)
    clearToSendN <= 1'b0;
    waitTx();
    clearToSendN <= 1'b1;
    cfg(8'h01, 8'h00, 8'h41);
    u_uart_line_partner.send({1'b1, 8'h5A}, 9);
    rdChk(`ADDR_STATUS, 8'h87, 8'h82);
    rdChk(`ADDR_RXDATA, 8'hFF, 8'h5A);
    u_uart_line_partner.send({1'b0, 8'hC3}, 9);
    rdChk(`ADDR_STATUS, 8'h86, 8'h84);
    rdChk(`ADDR_RXDATA, 8'hFF, 8'hC3);
    rdChk(`ADDR_STATUS, 8'h86, 8'h00);
    cfg(8'h01, 8'h00, 8'h00);
    u_uart_line_partner.send({1'b1, 8'hA5}, 8);
    rdChk(`ADDR_STATUS, 8'h80, 8'h00);
    u_uart_line_partner.irMode = 1'b1;
    u_uart_line_partner.listen = 1'b0;
    u_uart_line_partner.rxLine <= 1'b0;
    cfg(8'h01, 8'h04, 8'h40);
    u_uart_line_partner.send({1'b1, 8'h96}, 8);
    rdChk(`ADDR_RXDATA, 8'hFF, 8'h96);
    cfg(8'h01, 8'h04, 8'h80);
    pulses = 0;
    txWrite(8'h0F);
    waitTx();
    `CHK("ir pulses", 5, pulses)
    `CHK("words left", 0, expQ.size())
    test_done();
  end
endmodule : uart_irda_transceiver_bench
bind uart_irda_transceiver uart_irda_transceiver_monitor u_uart_irda_transceiver_monitor (
  .clock(clock), .rst(rst), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
  .wb_adr_i(wb_adr_i), .wb_dat_i(wb_dat_i), .wb_sel_i(wb_sel_i), .wb_dat_o(wb_dat_o),
  .wb_ack_o(wb_ack_o), .rxLine(rxLine), .clearToSendN(clearToSendN), .txLine(txLine),
  .driverEnable(driverEnable), .txIrq(txIrq));
